// ---- design/spd_ctrl.sv ----
// host-side power-down, reset and termination controller
`timescale 1ns/1ps
`default_nettype none
module spd_ctrl #(
	parameter int PD_MAX_CYCLES = spd_pkg::PD_MAX_CYC
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// user commands
	input wire logic i_cmd_valid,
	input wire spd_pkg::spd_cmd_t i_cmd,
	input wire logic [spd_pkg::BANK_W-1:0] i_cmd_bank,
	output logic o_cmd_accept,
	// user power-down and reset control
	input wire logic i_pd_req,
	input wire logic i_reset_req,
	input wire logic i_init_done,
	input wire logic i_pd_fast_exit,
	input wire logic i_dll_locked,
	input wire logic i_dll_reset_done,
	// user termination control
	input wire logic i_odt_req,
	input wire logic i_rtt_nom_en,
	// memory pins
	output logic o_cke,
	output logic o_reset_n,
	output logic o_odt,
	output spd_pkg::spd_cmd_t o_cmd,
	output logic [spd_pkg::BANK_W-1:0] o_cmd_bank,
	// status
	output logic o_init_req,
	output logic o_pd_active,
	output logic o_pd_precharge,
	output logic o_pd_slow,
	output logic o_dll_reset_req
);
	import spd_pkg::*;

	spd_state_t state;
	logic [NUM_BANKS-1:0] bank_open;
	logic slow_pending;
	logic dll_was_unlocked;
	logic op_done, rfc_done, xp_done, xpdll_done, cpded_done, pdmin_done, pdmax_done, ckehi_done, rst_done;
	logic take_cmd, go_entry, go_exit, read_cmd, dll_block;
	logic [TMR_W-1:0] op_len;

	//----------------------------------------------------------------------
	// timers
	//----------------------------------------------------------------------
	logic ld_op, ld_rfc, ld_entry, ld_exit, ld_rst;

	assign ld_op = take_cmd;
	assign ld_rfc = take_cmd && (i_cmd == CMD_REF);
	assign ld_entry = go_entry;
	assign ld_exit = go_exit;
	assign ld_rst = i_reset_req;

	always_comb begin
		case (i_cmd)
			CMD_RD, CMD_READ_WITH_AUTO_CLOSE: op_len = TMR_W'(RD_PDEN_CYC);
			CMD_WR: op_len = TMR_W'(WR_PDEN_CYC);
			CMD_MRS: op_len = TMR_W'(MOD_CK);
			CMD_ZQ: op_len = TMR_W'(ZQ_CK);
			default: op_len = TMR_W'(SHORT_PDEN_CYC);
		endcase
	end

	spd_timer #(.W(TMR_W)) u_op (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load(ld_op),
		.i_value(op_len), .o_done(op_done));
	spd_timer #(.W(TMR_W)) u_rfc (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load(ld_rfc),
		.i_value(TMR_W'(RFC_CYC)), .o_done(rfc_done));
	spd_timer #(.W(TMR_W)) u_cpded (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load(ld_entry),
		.i_value(TMR_W'(CPDED_CK)), .o_done(cpded_done));
	spd_timer #(.W(TMR_W)) u_pdmin (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load(ld_entry),
		.i_value(TMR_W'(PD_MIN_CYC)), .o_done(pdmin_done));
	spd_timer #(.W(TMR_W)) u_pdmax (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load(ld_entry),
		.i_value(TMR_W'(PD_MAX_CYCLES)), .o_done(pdmax_done));
	spd_timer #(.W(TMR_W)) u_xp (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load(ld_exit),
		.i_value(TMR_W'(XP_CYC)), .o_done(xp_done));
	spd_timer #(.W(TMR_W)) u_xpdll (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load(ld_exit),
		.i_value(TMR_W'(XPDLL_CYC)), .o_done(xpdll_done));
	spd_timer #(.W(TMR_W)) u_ckehi (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load(ld_exit),
		.i_value(TMR_W'(CKE_CYC)), .o_done(ckehi_done));
	// loaded at controller reset too, so the first reset pulse is full length
	spd_timer #(.W(TMR_W), .RST_VAL(TMR_W'(RST_CYC))) u_rst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
		.i_load(ld_rst), .i_value(TMR_W'(RST_CYC)), .o_done(rst_done));

	//----------------------------------------------------------------------
	// request decode
	//----------------------------------------------------------------------
	assign read_cmd = (i_cmd == CMD_RD) || (i_cmd == CMD_READ_WITH_AUTO_CLOSE);
	assign dll_block = (slow_pending && !xpdll_done) || o_dll_reset_req;
	assign take_cmd = (state == ST_IDLE) && !i_reset_req && i_cmd_valid && xp_done
		&& !(read_cmd && dll_block);
	// entry waits for mode, zq, read, write to finish and tXPDLL after a prior exit
	assign go_entry = (state == ST_IDLE) && !i_reset_req && !i_cmd_valid && i_pd_req
		&& op_done && xpdll_done && ckehi_done && rfc_done;
	// pd_max forces an exit even while the user still asks to stay down
	assign go_exit = (state == ST_PD) && !i_reset_req && pdmin_done
		&& (!i_pd_req || pdmax_done);

	//----------------------------------------------------------------------
	// state
	//----------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= ST_RST_HOLD;
		end else if (i_reset_req) begin
			state <= ST_RST_HOLD;
		end else begin
			case (state)
				ST_RST_HOLD: begin
					if (rst_done) begin
						state <= ST_INIT;
					end
				end
				ST_INIT: begin
					if (i_init_done) begin
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (go_entry) begin
						state <= ST_PD_ENTRY;
					end
				end
				ST_PD_ENTRY: begin
					if (cpded_done) begin
						state <= ST_PD;
					end
				end
				ST_PD: begin
					if (go_exit) begin
						state <= ST_PD_EXIT;
					end
				end
				ST_PD_EXIT: begin
					state <= ST_IDLE;
				end
				default: state <= ST_RST_HOLD;
			endcase
		end
	end

	//----------------------------------------------------------------------
	// bank tracking
	//----------------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b = b + 1) begin : g_bank
			always_ff @(posedge i_sys_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					bank_open[b] <= 1'b0;
				end else if (i_reset_req) begin
					bank_open[b] <= 1'b0;
				end else if (take_cmd && i_cmd == CMD_PREA) begin
					// checked first: the bank field of a close-all names no bank
					bank_open[b] <= 1'b0;
				end else if (take_cmd && (i_cmd_bank == BANK_W'(b))) begin
					if (i_cmd == CMD_ACT) begin
						bank_open[b] <= 1'b1;
					end else if (i_cmd == CMD_PRE || i_cmd == CMD_READ_WITH_AUTO_CLOSE) begin
						bank_open[b] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	//----------------------------------------------------------------------
	// power-down kind and dll bookkeeping
	//----------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pd_precharge <= 1'b0;
			o_pd_slow <= 1'b0;
			dll_was_unlocked <= 1'b0;
		end else if (go_entry) begin
			o_pd_precharge <= (bank_open == '0);
			o_pd_slow <= (bank_open == '0) && !i_pd_fast_exit;
			dll_was_unlocked <= !i_dll_locked;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			slow_pending <= 1'b0;
		end else if (go_exit && o_pd_slow) begin
			slow_pending <= 1'b1;
		end else if (xpdll_done || i_reset_req) begin
			slow_pending <= 1'b0;
		end
	end

	// set wins over the done pulse
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_dll_reset_req <= 1'b0;
		end else if (go_exit && dll_was_unlocked) begin
			o_dll_reset_req <= 1'b1;
		end else if (i_dll_reset_done || i_reset_req) begin
			o_dll_reset_req <= 1'b0;
		end
	end

	//----------------------------------------------------------------------
	// pins
	//----------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reset_n <= 1'b0;
			o_cke <= 1'b0;
		end else if (i_reset_req || state == ST_RST_HOLD) begin
			o_reset_n <= (state == ST_RST_HOLD) && rst_done && !i_reset_req;
			o_cke <= 1'b0;
		end else if (go_entry) begin
			o_cke <= 1'b0;
		end else if (go_exit) begin
			o_cke <= 1'b1;
		end else if (state == ST_INIT) begin
			o_cke <= i_init_done;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cmd <= CMD_NOP;
			o_cmd_bank <= '0;
			o_cmd_accept <= 1'b0;
		end else begin
			// nop on every entry, power-down and exit cycle
			o_cmd <= take_cmd ? i_cmd : CMD_NOP;
			o_cmd_bank <= take_cmd ? i_cmd_bank : '0;
			o_cmd_accept <= take_cmd;
		end
	end

	// odt held valid through power-down; off during reset, init and dll wait
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_odt <= 1'b0;
		end else begin
			o_odt <= i_odt_req && i_rtt_nom_en && !i_reset_req && !dll_block
				&& state != ST_RST_HOLD && state != ST_INIT;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_init_req <= 1'b0;
			o_pd_active <= 1'b0;
		end else begin
			o_init_req <= (state == ST_RST_HOLD && rst_done) || (state == ST_INIT && !i_init_done);
			o_pd_active <= go_entry || ((state == ST_PD_ENTRY || state == ST_PD) && !go_exit && !i_reset_req);
		end
	end

endmodule : spd_ctrl
`default_nettype wire

// ---- design/spd_pkg.sv ----
// constants and types for the power-down, reset and termination controller
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package spd_pkg;

	//----------------------------------------------------------------------
	// clock
	//----------------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;

	//----------------------------------------------------------------------
	// times in their own units
	//----------------------------------------------------------------------
	localparam int RST_LOW_NS = 100;
	localparam int XPDLL_NS = 24;
	localparam int XPDLL_MIN_CK = 10;
	localparam int WR_NS = 15;
	localparam int XP_NS = 6;
	localparam int PD_MIN_NS = 6;
	localparam int CKE_MIN_NS = 6;
	localparam int RFC_NS = 160;
	localparam int REFI_NS = 7800;
	localparam int PD_MAX_REFI = 9;
	localparam int CPDED_CK = 1;
	localparam int MOD_CK = 12;
	localparam int ZQ_CK = 64;
	localparam int CAS_LAT_CK = 6;
	localparam int CWL_CK = 5;

	//----------------------------------------------------------------------
	// derived cycle counts, least times rounded up
	//----------------------------------------------------------------------
	localparam int RST_CYC = (RST_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int XPDLL_NS_CYC = (XPDLL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int XPDLL_CYC = (XPDLL_NS_CYC > XPDLL_MIN_CK) ? XPDLL_NS_CYC : XPDLL_MIN_CK;
	localparam int WR_CYC = (WR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int XP_CYC = (XP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PD_MIN_CYC = (PD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CKE_CYC = (CKE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RFC_CYC = (RFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// longest time: rounded down
	localparam int PD_MAX_CYC = (PD_MAX_REFI * REFI_NS * 1000) / CLK_PERIOD_PS;
	localparam int RD_PDEN_CYC = CAS_LAT_CK + 4 + 1;
	localparam int WR_PDEN_CYC = CWL_CK + 4 + WR_CYC;
	localparam int SHORT_PDEN_CYC = 1;

	localparam int TMR_W = 16;
	localparam int NUM_BANKS = 8;
	localparam int BANK_W = 3;

	//----------------------------------------------------------------------
	// commands and states
	//----------------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_NOP, CMD_ACT, CMD_PRE, CMD_PREA, CMD_REF,
		CMD_RD, CMD_READ_WITH_AUTO_CLOSE, CMD_WR, CMD_MRS, CMD_ZQ
	} spd_cmd_t;

	typedef enum logic [2:0] {
		ST_RST_HOLD, ST_INIT, ST_IDLE, ST_PD_ENTRY, ST_PD, ST_PD_EXIT
	} spd_state_t;

endpackage : spd_pkg

// ---- design/spd_timer.sv ----
// down-counting interval timer
`timescale 1ns/1ps
`default_nettype none
module spd_timer #(
	parameter int W = 16,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// control
	input wire logic i_load,
	input wire logic [W-1:0] i_value,
	// status
	output logic o_done
);
	logic [W-1:0] count;

	// keeps the longer of the running and the new interval, so a short
	// command cannot cut the wait left by a read or write
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			count <= RST_VAL;
		end else if (i_load && (i_value >= count)) begin
			count <= i_value;
		end else if (count != '0) begin
			count <= count - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign o_done = (count == '0);
endmodule : spd_timer
`default_nettype wire

// ---- verification/spd_ctrl_sva.sv ----
// assertions on the ports of the power-down controller
`timescale 1ns/1ps
`default_nettype none
module spd_ctrl_sva #(
	parameter int PD_MAX_CYCLES = spd_pkg::PD_MAX_CYC
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// user inputs watched
	input wire logic i_reset_req,
	input wire logic i_rtt_nom_en,
	// pins and status
	input wire logic o_cmd_accept,
	input wire logic o_cke,
	input wire logic o_reset_n,
	input wire logic o_odt,
	input wire spd_pkg::spd_cmd_t o_cmd,
	input wire logic o_pd_active,
	input wire logic o_pd_slow
);
	import spd_pkg::*;
	logic [15:0] pd_cnt;
	// a memory reset overrides every timing below except the two reset-pin checks, which only the controller reset disables
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn || i_reset_req);
	//----------------------------------------------------------------------
	// helpers
	//----------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pd_cnt <= '0;
		end else begin
			pd_cnt <= o_pd_active ? pd_cnt + 16'h0001 : 16'h0000;
		end
	end
	sequence s_hi10;
		o_cke[*8] ##1 o_cke[*2];
	endsequence
	//----------------------------------------------------------------------
	// properties
	//----------------------------------------------------------------------
	property p_rd_pden; o_cmd == CMD_RD |-> s_hi10; endproperty
	a_rd_pden: assert property (p_rd_pden) else $error("cke fell during read");
	property p_wr_pden; o_cmd == CMD_WR |-> s_hi10; endproperty
	a_wr_pden: assert property (p_wr_pden) else $error("cke fell during write recovery");
	property p_pd_nop; o_pd_active |-> o_cmd == CMD_NOP && !o_cmd_accept; endproperty
	a_pd_nop: assert property (p_pd_nop) else $error("command in power-down");
	property p_pd_min; $fell(o_cke) && o_reset_n |=> !o_cke; endproperty
	a_pd_min: assert property (p_pd_min) else $error("power-down too short");
	property p_pd_max; pd_cnt <= PD_MAX_CYCLES + 2; endproperty
	a_pd_max: assert property (p_pd_max) else $error("power-down too long");
	property p_exit_nop; $fell(o_pd_active) && o_reset_n |-> o_cke && o_cmd == CMD_NOP; endproperty
	a_exit_nop: assert property (p_exit_nop) else $error("exit without nop");
	property p_slow_rd; $fell(o_pd_active) && o_pd_slow |-> (o_cmd != CMD_RD && o_cmd != CMD_READ_WITH_AUTO_CLOSE)[*8]; endproperty
	a_slow_rd: assert property (p_slow_rd) else $error("read before dll relock");
	property p_reentry; $fell(o_pd_active) && o_reset_n |-> o_cke[*8]; endproperty
	a_reentry: assert property (p_reentry) else $error("re-entry too soon");
	property p_odt_en; !i_rtt_nom_en |=> !o_odt; endproperty
	a_odt_en: assert property (p_odt_en) else $error("termination while disabled");
	property p_rst_low; @(posedge i_sys_clk) disable iff (!i_rstn) $fell(o_reset_n) |-> (!o_reset_n)[*8] ##1 (!o_reset_n)[*5]; endproperty
	a_rst_low: assert property (p_rst_low) else $error("reset pulse too short");
	property p_rst_cke; @(posedge i_sys_clk) disable iff (!i_rstn) $rose(o_reset_n) |-> !o_cke; endproperty
	a_rst_cke: assert property (p_rst_cke) else $error("cke high at reset release");
endmodule : spd_ctrl_sva
`default_nettype wire

// ---- verification/spd_dram_model.sv ----
// behavioural memory device on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module spd_dram_model (
	// clock
	input wire logic i_sys_clk,
	// pins from the controller
	input wire logic i_cke,
	input wire logic i_reset_n,
	input wire logic i_odt,
	input wire spd_pkg::spd_cmd_t i_cmd,
	input wire logic [spd_pkg::BANK_W-1:0] i_bank,
	// mode bits
	input wire logic i_fast_exit,
	input wire logic i_rtt_nom_en,
	// device state
	output logic o_in_pd,
	output logic o_pd_prech,
	output logic o_dll_on,
	output logic o_rtt_on
);
	import spd_pkg::*;
	logic [NUM_BANKS-1:0] open_banks;
	logic cke_q;
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			open_banks <= '0;
			cke_q <= 1'b0;
			o_in_pd <= 1'b0;
			o_pd_prech <= 1'b0;
			o_dll_on <= 1'b1;
			o_rtt_on <= 1'b0;
		end else begin
			cke_q <= i_cke;
			// only the pins named below are heard in power-down
			if (i_cke && cke_q) begin
				case (i_cmd)
					CMD_ACT: open_banks[i_bank] <= 1'b1;
					CMD_PRE, CMD_READ_WITH_AUTO_CLOSE: open_banks[i_bank] <= 1'b0;
					CMD_PREA: open_banks <= '0;
					default: ;
				endcase
			end
			if (cke_q && !i_cke && i_cmd == CMD_NOP) begin
				o_in_pd <= 1'b1;
				o_pd_prech <= open_banks == '0;
				o_dll_on <= open_banks != '0 || i_fast_exit;
			end
			if (!cke_q && i_cke) begin
				o_in_pd <= 1'b0;
				o_dll_on <= 1'b1;
			end
			// nominal only, no dll-disable mode modelled
			o_rtt_on <= i_odt && i_rtt_nom_en;
		end
	end
endmodule : spd_dram_model
`default_nettype wire

// ---- verification/tb_spd_ctrl.sv ----
// testbench for the power-down, reset and termination controller
`timescale 1ns/1ps
`default_nettype none
module tb_spd_ctrl;
	import spd_pkg::*;
	localparam int PDM = 40;
	typedef struct packed {spd_cmd_t c; logic [BANK_W-1:0] b;} spd_row_t;
	logic i_sys_clk = 1'b0, i_rstn, i_cmd_valid = 1'b0, i_pd_req = 1'b0, i_reset_req = 1'b0;
	logic i_init_done = 1'b0, i_pd_fast_exit = 1'b0, i_dll_locked = 1'b1, i_dll_reset_done = 1'b0;
	logic i_odt_req = 1'b0, i_rtt_nom_en = 1'b1;
	spd_cmd_t i_cmd = CMD_NOP, o_cmd;
	logic [BANK_W-1:0] i_cmd_bank = 3'h0, o_cmd_bank;
	logic o_cmd_accept, o_cke, o_reset_n, o_odt, o_init_req, o_pd_active, o_pd_precharge, o_pd_slow;
	logic o_dll_reset_req, m_in_pd, m_pd_prech, m_dll_on, m_rtt_on;
	int failures = 0, checks_done = 0, n;
	spd_row_t rows[11] = '{'{CMD_ACT, 3'h2}, '{CMD_ACT, 3'h0}, '{CMD_PRE, 3'h2}, '{CMD_PREA, 3'h0},
		'{CMD_REF, 3'h0}, '{CMD_MRS, 3'h0}, '{CMD_ZQ, 3'h0}, '{CMD_ACT, 3'h1}, '{CMD_WR, 3'h1},
		'{CMD_RD, 3'h1}, '{CMD_READ_WITH_AUTO_CLOSE, 3'h1}};
	always #4 i_sys_clk = ~i_sys_clk;
	spd_ctrl #(.PD_MAX_CYCLES(PDM)) spd_ctrl_i (.i_sys_clk, .i_rstn, .i_cmd_valid, .i_cmd, .i_cmd_bank,
		.o_cmd_accept, .i_pd_req, .i_reset_req, .i_init_done, .i_pd_fast_exit, .i_dll_locked,
		.i_dll_reset_done, .i_odt_req, .i_rtt_nom_en, .o_cke, .o_reset_n, .o_odt, .o_cmd, .o_cmd_bank,
		.o_init_req, .o_pd_active, .o_pd_precharge, .o_pd_slow, .o_dll_reset_req);
	spd_dram_model spd_dram_model_i (.i_sys_clk, .i_cke(o_cke), .i_reset_n(o_reset_n), .i_odt(o_odt),
		.i_cmd(o_cmd), .i_bank(o_cmd_bank), .i_fast_exit(i_pd_fast_exit), .i_rtt_nom_en,
		.o_in_pd(m_in_pd), .o_pd_prech(m_pd_prech), .o_dll_on(m_dll_on), .o_rtt_on(m_rtt_on));
	//----------------------------------------------------------------------
	// tasks
	//----------------------------------------------------------------------
	task automatic chk_bit(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask : chk_bit
	task automatic chk_cmd(input spd_cmd_t got, input spd_cmd_t exp, input logic [2:0] gb, input logic [2:0] eb);
		checks_done++;
		if (got !== exp || gb !== eb) begin
			failures++;
			$display("[ERR] %0t command %s seen %s", $time, exp.name(), got.name());
		end
	endtask : chk_cmd
	// one-cycle pulses: a held request would be taken twice before accept shows
	task automatic send(input spd_cmd_t c, input logic [2:0] b, output int k);
		k = 0;
		do begin
			@(posedge i_sys_clk);
			i_cmd_valid <= 1'b1;
			i_cmd <= c;
			i_cmd_bank <= b;
			@(posedge i_sys_clk);
			i_cmd_valid <= 1'b0;
			@(negedge i_sys_clk);
			k++;
		end while (o_cmd_accept !== 1'b1 && k < 50);
		chk_cmd(o_cmd, c, o_cmd_bank, b);
	endtask : send
	task automatic wait_pd(input logic want, output int k);
		k = 0;
		while (o_pd_active !== want && k < 200) begin
			@(negedge i_sys_clk);
			k++;
		end
		chk_bit(o_pd_active, want, "power-down state not reached");
	endtask : wait_pd
	task automatic reinit();
		int k;
		k = 0;
		while (o_reset_n !== 1'b1 && k < 100) begin
			@(negedge i_sys_clk);
			k++;
		end
		chk_bit(k >= RST_CYC, 1'b1, "reset pin low too short");
		chk_bit(o_cke, 1'b0, "cke high at reset release");
		chk_bit(o_init_req, 1'b1, "no init request");
		@(posedge i_sys_clk);
		i_init_done <= 1'b1;
		@(posedge i_sys_clk);
		i_init_done <= 1'b0;
		@(negedge i_sys_clk);
		chk_bit(o_cke, 1'b1, "cke low after init");
	endtask : reinit
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	//----------------------------------------------------------------------
	// sequence
	//----------------------------------------------------------------------
	initial begin
		#(8 * 20000);
		failures++;
		summarize();
	end
	initial begin
		// driven in the first step so the asynchronous reset sees a falling edge
		i_rstn <= 1'b0;
		@(negedge i_sys_clk);
		chk_bit(o_reset_n | o_cke | o_odt, 1'b0, "pins active in reset");
		repeat (2) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		reinit();
		foreach (rows[k]) send(rows[k].c, rows[k].b, n);
		@(posedge i_sys_clk);
		i_pd_req <= 1'b1;
		i_odt_req <= 1'b1;
		wait_pd(1'b1, n);
		chk_bit(o_pd_precharge & o_pd_slow, 1'b1, "not slow precharge pd");
		@(negedge i_sys_clk);
		chk_bit(m_pd_prech & ~m_dll_on, 1'b1, "device not in slow pd");
		@(posedge i_sys_clk);
		i_pd_req <= 1'b0;
		wait_pd(1'b0, n);
		send(CMD_RD, 3'h0, n);
		chk_bit(2 * n > XPDLL_CYC, 1'b1, "read too soon after slow exit");
		send(CMD_ACT, 3'h5, n);
		@(posedge i_sys_clk);
		i_pd_req <= 1'b1;
		wait_pd(1'b1, n);
		chk_bit(o_pd_precharge | o_pd_slow, 1'b0, "active pd flagged wrong");
		@(negedge i_sys_clk);
		chk_bit(~m_pd_prech & m_dll_on, 1'b1, "device not in active pd");
		wait_pd(1'b0, n);
		chk_bit(n <= PDM + 2 && n + 3 >= PDM, 1'b1, "power-down length wrong");
		@(posedge i_sys_clk);
		i_pd_req <= 1'b0;
		send(CMD_PREA, 3'h0, n);
		@(posedge i_sys_clk);
		i_pd_fast_exit <= 1'b1;
		i_dll_locked <= 1'b0;
		i_pd_req <= 1'b1;
		wait_pd(1'b1, n);
		chk_bit(o_pd_slow, 1'b0, "fast exit shown slow");
		@(posedge i_sys_clk);
		i_pd_req <= 1'b0;
		wait_pd(1'b0, n);
		@(negedge i_sys_clk);
		chk_bit(o_dll_reset_req & ~o_odt, 1'b1, "dll block missing");
		@(posedge i_sys_clk);
		i_dll_locked <= 1'b1;
		i_dll_reset_done <= 1'b1;
		@(posedge i_sys_clk);
		i_dll_reset_done <= 1'b0;
		repeat (3) @(negedge i_sys_clk);
		chk_bit(o_dll_reset_req | ~o_odt | ~m_rtt_on, 1'b0, "termination not restored");
		@(posedge i_sys_clk);
		i_rtt_nom_en <= 1'b0;
		repeat (3) @(negedge i_sys_clk);
		chk_bit(o_odt | m_rtt_on, 1'b0, "termination while disabled");
		@(posedge i_sys_clk);
		i_rtt_nom_en <= 1'b1;
		i_pd_req <= 1'b1;
		wait_pd(1'b1, n);
		@(posedge i_sys_clk);
		i_reset_req <= 1'b1;
		@(posedge i_sys_clk);
		i_reset_req <= 1'b0;
		i_pd_req <= 1'b0;
		@(negedge i_sys_clk);
		chk_bit(o_reset_n | o_cke | o_odt | m_in_pd, 1'b0, "power-down kept in reset");
		reinit();
		summarize();
	end
endmodule : tb_spd_ctrl
bind spd_ctrl spd_ctrl_sva #(.PD_MAX_CYCLES(PD_MAX_CYCLES)) spd_ctrl_sva_i (.i_sys_clk, .i_rstn, .i_reset_req,
	.i_rtt_nom_en, .o_cmd_accept, .o_cke, .o_reset_n, .o_odt, .o_cmd, .o_pd_active, .o_pd_slow);
`default_nettype wire
